// [rtl/store_exec.sv]
`timescale 1ns/1ps
module store_exec
  import store_exec_pkg::*;
(
  // clock, reset, enable
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // interrupt
  output logic             IRQ,
  // instruction issue
  input  wire logic        INSTR_VALID,
  output logic             INSTR_READY,
  input  wire logic [31:0] INSTR,
  input  wire logic        COND_PASS,
  input  wire logic        CARRY_FLAG,
  // register file read and writeback
  output logic      [3:0]  RF_ADDR_A,
  output logic      [3:0]  RF_ADDR_B,
  output logic      [3:0]  RF_ADDR_C,
  input  wire logic [31:0] RF_DATA_A,
  input  wire logic [31:0] RF_DATA_B,
  input  wire logic [31:0] RF_DATA_C,
  output logic             WB_EN,
  output logic      [3:0]  WB_REG,
  output logic      [31:0] WB_DATA,
  // memory write port
  output mem_req_t         MEM_OUT,
  input  wire logic        MEM_ACK,
  input  wire logic        MEM_PROT_FAULT,
  input  wire logic        MEM_BUS_FAULT,
  // completion
  output logic             DONE,
  output result_t          RESULT
);

  // ==========================================================
  // state record
  // st: sequencer position
  // mem: request shown to memory
  // dual: a second word is owed
  // second_data: latched at accept
  // wb_pend: base update owed
  // wb_addr: value for that update
  // res: result of last instruction
  // the register file may change in a
  // long memory wait, so operands are
  // latched once at accept
  typedef struct packed {
    state_t      st;
    mem_req_t    mem;
    logic        dual;
    logic [31:0] second_data;
    logic        wb_pend;
    logic [3:0]  wb_reg;
    logic [31:0] wb_addr;
    logic        wb_en;
    logic        done_p;
    result_t     res;
    logic        ctrl_en;
    logic [5:0]  irq_stat;
    logic [5:0]  irq_mask;
    logic [31:0] fault_addr;
    logic [31:0] exec_count;
    logic [31:0] prdata;
  } core_state_t;

  core_state_t s_r;
  core_state_t s_nxt;
  decode_t     dec;
  logic [31:0] shifted;
  logic [31:0] offset_addr;
  logic [31:0] access_addr;
  logic        accept;
  logic        apb_setup;
  logic        apb_write;
  logic [5:0]  ev;
  logic [5:0]  w1c;

  // ==========================================================
  // bus address decode for the error answer; the read mux decodes the offset in its own case
  // unmapped offsets error and read zero;
  // writes there are dropped
  function automatic logic reg_hit(input logic [7:0] a);
    case (a)
      OFS_CTRL, OFS_STATUS, OFS_IRQ_STAT,
      OFS_IRQ_MASK, OFS_FAULT_ADDR, OFS_EXEC_COUNT: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : reg_hit

  function automatic logic [31:0] read_mux(input core_state_t s, input logic [7:0] a);
    case (a)
      OFS_CTRL:       return {31'h0000_0000, s.ctrl_en};
      OFS_STATUS:     return {24'h00_0000, s.st != ST_IDLE, s.wb_pend, s.res};
      OFS_IRQ_STAT:   return {26'h000_0000, s.irq_stat};
      OFS_IRQ_MASK:   return {26'h000_0000, s.irq_mask};
      OFS_FAULT_ADDR: return s.fault_addr;
      OFS_EXEC_COUNT: return s.exec_count;
      default:        return 32'h0000_0000;
    endcase
  endfunction : read_mux

  // ==========================================================
  // decode and operand paths
  // decode is combinational from the
  // offered word, so fields are valid
  // in the cycle of acceptance
  store_decoder u_decoder (
    .instr (INSTR),
    .dec   (dec)
  );

  // offset register through the shifter, carry feeds rotate
  offset_shifter u_shifter (
    .value      (RF_DATA_C),
    .shift_type (dec.shift_type),
    .amount     (dec.shift_amt),
    .carry_in   (CARRY_FLAG),
    .result     (shifted)
  );

  // register numbers go straight to the register file
  // port c serves the dual second source
  // or the byte store offset register;
  // only one of them is live at a time
  assign RF_ADDR_A = dec.base_reg;
  assign RF_ADDR_B = dec.source_reg;
  assign RF_ADDR_C = (dec.op == OP_DUAL) ? dec.second_source_reg : dec.offset_index_reg;

  // add or subtract the scaled offset, index picks the address
  assign offset_addr = dec.add ? (RF_DATA_A + dec.offset_ext)
                               : (RF_DATA_A - dec.offset_ext);
  assign access_addr = dec.index ? offset_addr : RF_DATA_A;
  // both sums form every cycle; the
  // subtraction wraps like register math
  // post-indexed forms write back the
  // offset address, not the access one

  // ==========================================================
  // handshakes
  // issue refused while busy, while
  // switched off, or while enable is low
  // the bus never waits while running,
  // so ready mirrors the enable; a low
  // enable stretches the access phase
  assign INSTR_READY = CE && s_r.ctrl_en && (s_r.st == ST_IDLE);
  assign accept      = INSTR_VALID && INSTR_READY;
  assign apb_setup   = PSEL && !PENABLE;
  assign apb_write   = PSEL && PENABLE && PWRITE && CE;
  assign PREADY      = CE; // no wait states while running
  assign PSLVERR     = PSEL && PENABLE && !reg_hit(PADDR);
  assign w1c         = (apb_write && (PADDR == OFS_IRQ_STAT)) ? PWDATA[5:0] : 6'h00;

  // ==========================================================
  // next state
  // one copy of the state is filled here;
  // pulses clear by default, last a cycle
  always_comb begin
    s_nxt        = s_r;
    s_nxt.done_p = 1'b0;
    s_nxt.wb_en  = 1'b0;
    ev           = 6'h00;
    case (s_r.st)
      // checks run in fixed priority; a
      // refused, skipped or flagged form
      // ends in one cycle and never
      // touches memory or the base
      ST_IDLE: begin
        if (accept) begin
          s_nxt.res      = '0;
          s_nxt.res.done = 1'b1;
          s_nxt.dual     = (dec.op == OP_DUAL);
          s_nxt.wb_pend  = 1'b0;
          s_nxt.mem      = '0;
          if (dec.related) begin
            s_nxt.res.related = 1'b1;
            s_nxt.done_p      = 1'b1;
          end else if (dec.undef) begin
            s_nxt.res.undef = 1'b1;
            s_nxt.done_p    = 1'b1;
          end else if (!COND_PASS) begin
            s_nxt.done_p = 1'b1;
          end else if (dec.unpred) begin
            // unpredictable forms are flagged and not carried out
            s_nxt.res.unpred = 1'b1;
            s_nxt.done_p     = 1'b1;
          end else begin
            s_nxt.st      = ST_FIRST;
            s_nxt.mem.req = 1'b1;
            // latched now; memory sees them
            // from the next cycle on
            case (dec.op)
              OP_BYTE_REG: begin
                s_nxt.mem.addr  = RF_DATA_A + shifted;
                s_nxt.mem.wdata = {24'h00_0000, RF_DATA_B[BYTE_MSB:0]};
              end
              OP_BYTE_UNPRIV: begin
                s_nxt.mem.addr   = RF_DATA_A + dec.offset_ext;
                s_nxt.mem.wdata  = {24'h00_0000, RF_DATA_B[BYTE_MSB:0]};
                s_nxt.mem.unpriv = 1'b1;
              end
              OP_DUAL: begin
                s_nxt.mem.addr    = access_addr;
                s_nxt.mem.wdata   = RF_DATA_B;
                s_nxt.mem.word    = 1'b1;
                s_nxt.second_data = RF_DATA_C;
                s_nxt.wb_pend     = dec.wback;
                s_nxt.wb_reg      = dec.base_reg;
                s_nxt.wb_addr     = offset_addr;
              end
              default: begin
                s_nxt.st      = ST_IDLE;
                s_nxt.mem.req = 1'b0;
              end
            endcase
          end
        end
      end
      ST_FIRST, ST_SECOND: begin
        // request held stable until the memory answers
        // a fault on either word skips the
        // rest, base update included, so the
        // base changes only after both stores
        // the counter sees clean completions
        if (MEM_ACK) begin
          if (MEM_PROT_FAULT || MEM_BUS_FAULT) begin
            // a rejected write abandons the rest, base untouched
            s_nxt.res.prot   = MEM_PROT_FAULT;
            s_nxt.res.bus    = MEM_BUS_FAULT;
            s_nxt.fault_addr = s_r.mem.addr;
            s_nxt.mem.req    = 1'b0;
            s_nxt.st         = ST_IDLE;
            s_nxt.done_p     = 1'b1;
          end else if (s_r.st == ST_FIRST && s_r.dual) begin
            s_nxt.mem.addr  = s_r.mem.addr + DUAL_STEP;
            s_nxt.mem.wdata = s_r.second_data;
            s_nxt.st        = ST_SECOND;
          end else begin
            s_nxt.wb_en      = s_r.wb_pend;
            s_nxt.mem.req    = 1'b0;
            s_nxt.st         = ST_IDLE;
            s_nxt.done_p     = 1'b1;
            s_nxt.exec_count = s_r.exec_count + 32'h0000_0001;
          end
        end
      end
      default: begin
        s_nxt.st      = ST_IDLE;
        s_nxt.mem.req = 1'b0;
      end
    endcase

    // every completion raises its flags as events
    // done is always one of them, so it
    // can give one interrupt per store
    if (s_nxt.done_p) begin
      ev = s_nxt.res;
    end

    // register writes; a new event beats a clear in the same cycle
    if (apb_write && (PADDR == OFS_CTRL)) begin
      s_nxt.ctrl_en = PWDATA[0];
    end
    if (apb_write && (PADDR == OFS_IRQ_MASK)) begin
      s_nxt.irq_mask = PWDATA[5:0];
    end
    s_nxt.irq_stat = (s_r.irq_stat & ~w1c) | ev;

    // read data captured in the setup phase, shown in the access phase
    // early capture keeps reads off the
    // ready path; the cost is a view one
    // cycle older than the access phase
    if (apb_setup) begin
      s_nxt.prdata = read_mux(s_r, PADDR);
    end
  end

  // ==========================================================
  // single state register, frozen while the enable is low
  // reset clears all but the enable,
  // which comes up on, so stores issue
  // with no software setup
  // a low enable holds every flag and
  // request: a wait is just stretched
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s_r          <= '0;
      s_r.ctrl_en  <= CTRL_EN_RST;
      s_r.irq_mask <= IRQ_MASK_RST;
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  // data outputs come from the state
  // register; only handshake, error answers
  // and register file addresses are combinational
  // writeback data is the offset address
  // latched at accept
  assign PRDATA  = s_r.prdata;
  assign IRQ     = |(s_r.irq_stat & s_r.irq_mask);
  assign MEM_OUT = s_r.mem;
  assign WB_EN   = s_r.wb_en;
  assign WB_REG  = s_r.wb_reg;
  assign WB_DATA = s_r.wb_addr;
  assign DONE    = s_r.done_p;
  assign RESULT  = s_r.res;

endmodule : store_exec

// [rtl/store_exec_pkg.sv]
package store_exec_pkg;

  // ==========================================================
  // register map (byte addresses on the APB)
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h0C;
  localparam logic [7:0] OFS_FAULT_ADDR = 8'h10;
  localparam logic [7:0] OFS_EXEC_COUNT = 8'h14;

  // ==========================================================
  // reset values and event bit positions
  localparam logic       CTRL_EN_RST    = 1'b1;
  localparam int         NUM_EV         = 6;
  localparam logic [5:0] IRQ_MASK_RST   = 6'h00;
  localparam int         EV_DONE        = 0;
  localparam int         EV_UNDEF       = 1;
  localparam int         EV_UNPRED      = 2;
  localparam int         EV_RELATED     = 3;
  localparam int         EV_PROT        = 4;
  localparam int         EV_BUS         = 5;

  // ==========================================================
  // encoding fields
  localparam logic [11:0] OP_BYTE_HI     = 12'hF80;
  localparam logic [3:0]  OP_UNPRIV_SEL  = 4'hE;
  localparam logic [5:0]  OP_BYTE_REG_Z  = 6'h00;
  localparam logic [6:0]  OP_DUAL_HI     = 7'h74;
  localparam logic [3:0]  REG_SP         = 4'hD;
  localparam logic [3:0]  REG_PC         = 4'hF;
  localparam logic [3:0]  REG_ALL_ONES   = 4'hF;
  localparam logic [31:0] DUAL_STEP      = 32'h0000_0004;
  localparam int          BYTE_MSB       = 7;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    SHIFT_LSL = 2'b00,
    SHIFT_LSR = 2'b01,
    SHIFT_ASR = 2'b10,
    SHIFT_ROR = 2'b11
  } shift_t;

  typedef enum logic [1:0] {
    OP_NONE        = 2'b00,
    OP_BYTE_REG    = 2'b01,
    OP_BYTE_UNPRIV = 2'b10,
    OP_DUAL        = 2'b11
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_FIRST  = 2'b01,
    ST_SECOND = 2'b10
  } state_t;

  typedef struct packed {
    op_t         op;
    logic        undef;
    logic        unpred;
    logic        related;
    logic [3:0]  base_reg;
    logic [3:0]  source_reg;
    logic [3:0]  second_source_reg;
    logic [3:0]  offset_index_reg;
    shift_t      shift_type;
    logic [4:0]  shift_amt;
    logic [31:0] offset_ext;
    logic        index;
    logic        add;
    logic        wback;
  } decode_t;

  // bit order matches the event positions above
  typedef struct packed {
    logic bus;
    logic prot;
    logic related;
    logic unpred;
    logic undef;
    logic done;
  } result_t;

  typedef struct packed {
    logic        req;
    logic        unpriv;
    logic        word;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

  function automatic logic sp_or_pc(input logic [3:0] r);
    return (r == REG_SP) || (r == REG_PC);
  endfunction : sp_or_pc

endpackage : store_exec_pkg

// [rtl/offset_shifter.sv]
`timescale 1ns/1ps
module offset_shifter
  import store_exec_pkg::*;
(
  // operand
  input  wire logic [31:0] value,
  input  wire shift_t      shift_type,
  input  wire logic [4:0]  amount,
  input  wire logic        carry_in,
  // result
  output logic      [31:0] result
);

  logic [63:0] doubled;

  // ==========================================================
  // rotate via a doubled word, so one path covers ror
  assign doubled = {value, value} >> amount;

  // amount zero on ror means rotate through carry
  always_comb begin
    case (shift_type)
      SHIFT_LSL: result = value << amount;
      SHIFT_LSR: result = value >> amount;
      SHIFT_ASR: result = 32'($signed(value) >>> amount);
      SHIFT_ROR: result = (amount == 5'h0) ? {carry_in, value[31:1]} : doubled[31:0];
      default:   result = value;
    endcase
  end

endmodule : offset_shifter

// [rtl/store_decoder.sv]
`timescale 1ns/1ps
module store_decoder
  import store_exec_pkg::*;
(
  // instruction word, first halfword in the upper bits
  input  wire logic [31:0] instr,
  // decoded fields
  output decode_t          dec
);

  logic is_byte_reg;
  logic is_unpriv;
  logic is_dual;

  // ==========================================================
  // opcode match
  assign is_byte_reg = (instr[31:20] == OP_BYTE_HI) && (instr[11:6] == OP_BYTE_REG_Z);
  assign is_unpriv   = (instr[31:20] == OP_BYTE_HI) && (instr[11:8] == OP_UNPRIV_SEL);
  assign is_dual     = (instr[31:25] == OP_DUAL_HI) && instr[22] && !instr[20];

  // field extraction and encoding checks
  always_comb begin
    dec                   = '0;
    dec.base_reg          = instr[19:16];
    dec.source_reg        = instr[15:12];
    dec.second_source_reg = instr[11:8];
    dec.offset_index_reg  = instr[3:0];
    dec.shift_type        = SHIFT_LSL;
    dec.index             = 1'b1;
    dec.add               = 1'b1;
    if (is_byte_reg) begin
      dec.op        = OP_BYTE_REG;
      dec.shift_amt = {3'h0, instr[5:4]};
      dec.undef     = (instr[19:16] == REG_ALL_ONES);
      dec.unpred    = sp_or_pc(instr[15:12]) || sp_or_pc(instr[3:0]);
    end else if (is_unpriv) begin
      dec.op         = OP_BYTE_UNPRIV;
      dec.offset_ext = {24'h00_0000, instr[7:0]};
      dec.undef      = (instr[19:16] == REG_ALL_ONES);
      dec.unpred     = sp_or_pc(instr[15:12]);
    end else if (is_dual) begin
      dec.op         = OP_DUAL;
      dec.related    = !instr[24] && !instr[21];
      dec.offset_ext = {22'h00_0000, instr[7:0], 2'b00};
      dec.index      = instr[24];
      dec.add        = instr[23];
      dec.wback      = instr[21];
      dec.unpred     = (instr[21] && ((instr[19:16] == instr[15:12]) ||
                                      (instr[19:16] == instr[11:8]))) ||
                       (instr[19:16] == REG_PC) || sp_or_pc(instr[15:12]) ||
                       sp_or_pc(instr[11:8]);
    end else begin
      dec.undef = 1'b1;
    end
  end

endmodule : store_decoder

// [testbench/mem_port_model.sv]
`timescale 1ns/1ps
module mem_port_model
  import store_exec_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // write request and knobs
  input  wire mem_req_t   req,
  input  wire logic [3:0] wait_n,
  input  wire logic [1:0] fault_sel,
  // answer
  output logic            ack,
  output logic            prot_fault,
  output logic            bus_fault
);
  // ======
  logic [3:0] cnt_r;
  logic       junk_r;
  // ack once the request has waited wait_n cycles
  assign ack        = req.req && cnt_r == wait_n;
  // junk outside an ack, so a block that ignores ack is caught
  assign prot_fault = ack ? fault_sel[0] : junk_r;
  assign bus_fault  = ack ? fault_sel[1] : ~junk_r;
  // wait counter and a line that flips every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= 4'h0;
      junk_r <= 1'b0;
    end else begin
      cnt_r  <= (ack || !req.req) ? 4'h0 : cnt_r + 4'h1;
      junk_r <= ~junk_r;
    end
  end
endmodule : mem_port_model

// [testbench/store_exec_chk.sv]
`timescale 1ns/1ps
module store_exec_chk
  import store_exec_pkg::*;
(
  // clock and reset
  input wire logic        MCLK,
  input wire logic        RST_N,
  // bus and issue
  input wire logic        CE,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PREADY,
  input wire logic        INSTR_VALID,
  input wire logic        INSTR_READY,
  input wire logic [31:0] INSTR,
  input wire logic        COND_PASS,
  input wire logic [31:0] RF_DATA_A,
  input wire logic [31:0] RF_DATA_B,
  // memory and results
  input wire logic        WB_EN,
  input wire mem_req_t    MEM_OUT,
  input wire logic        MEM_ACK,
  input wire logic        MEM_PROT_FAULT,
  input wire logic        MEM_BUS_FAULT,
  input wire logic        DONE,
  input wire result_t     RESULT
);
  // ======
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  logic       acc, flt, ubs;
  logic [7:0] imm_r;
  assign acc = INSTR_VALID && INSTR_READY;
  assign flt = MEM_OUT.req && MEM_ACK && (MEM_PROT_FAULT || MEM_BUS_FAULT);
  assign ubs = INSTR[31:20] == 12'hF80 && INSTR[11:8] == 4'hE;
  // offset field of the word offered last cycle
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N)
      imm_r <= 8'h00;
    else
      imm_r <= INSTR[7:0];
  end
  // ======
  ready_follows_ce_a: assert property (PSEL && PENABLE |-> PREADY == CE)
    else $error("ready does not follow enable");
  req_held_a: assert property (MEM_OUT.req && !MEM_ACK |=> MEM_OUT.req && $stable(MEM_OUT))
    else $error("write request dropped or changed");
  second_word_a: assert property (MEM_OUT.req && MEM_OUT.word && MEM_ACK && !flt |=> DONE ||
    (MEM_OUT.req && MEM_OUT.addr == $past(MEM_OUT.addr) + DUAL_STEP))
    else $error("second word not at plus four");
  fault_stops_a: assert property (flt |=> DONE && !MEM_OUT.req && !WB_EN &&
    RESULT.prot == $past(MEM_PROT_FAULT) && RESULT.bus == $past(MEM_BUS_FAULT))
    else $error("fault not reported");
  cond_fail_a: assert property (acc && !COND_PASS |=> DONE && !WB_EN && !MEM_OUT.req)
    else $error("store ran with failed condition");
  undef_base_a: assert property (acc && ubs && INSTR[19:16] == 4'hF |=> DONE && RESULT.undef)
    else $error("base all ones not undefined");
  related_pass_a: assert property (acc && INSTR[31:25] == 7'h74 && INSTR[22] && !INSTR[20] &&
    !INSTR[24] && !INSTR[21] |=> DONE && RESULT.related && !MEM_OUT.req)
    else $error("related pattern not handed on");
  unpriv_byte_a: assert property (acc && COND_PASS && ubs && INSTR[19:16] != 4'hF &&
    INSTR[15:12] != 4'hD && INSTR[15:12] != 4'hF |=> MEM_OUT.req && MEM_OUT.unpriv &&
    !MEM_OUT.word && MEM_OUT.addr == $past(RF_DATA_A) + {24'h0, imm_r} &&
    MEM_OUT.wdata[7:0] == 8'($past(RF_DATA_B)))
    else $error("unprivileged byte request wrong");
  wb_after_store_a: assert property (WB_EN |-> DONE && !RESULT.prot && !RESULT.bus && $past(MEM_ACK))
    else $error("writeback not after stores");
  cover property (flt);
  cover property (WB_EN);
  cover property (acc && !COND_PASS);
endmodule : store_exec_chk

bind store_exec store_exec_chk chk_i (.MCLK, .RST_N, .CE, .PSEL, .PENABLE, .PREADY, .INSTR_VALID,
  .INSTR_READY, .INSTR, .COND_PASS, .RF_DATA_A, .RF_DATA_B, .WB_EN, .MEM_OUT, .MEM_ACK,
  .MEM_PROT_FAULT, .MEM_BUS_FAULT, .DONE, .RESULT);

// [testbench/store_exec_tb.sv]
`timescale 1ns/1ps
module store_exec_tb;
  import store_exec_pkg::*;
  // ======
  logic        mclk, rst_n, ce, psel, penable, pwrite, pready, pslverr, irq, e;
  logic        ivalid, irdy, cond, carry, wb_en, done, ack, pf, bf;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, instr, wb_data, wbd, q, off, oa, ad;
  logic [3:0]  ra, rb, rc, wb_reg, wbr, wait_n;
  logic [1:0]  fault_sel;
  mem_req_t    mem;
  result_t     res;
  logic [31:0] rf [16];
  mem_req_t    log_q [$];
  int          errors, checks_done, cyc, wb_cnt;
  logic [10:0] tab [4] = '{11'h7FF, 11'h401, 11'h110, 11'h300};
  logic [11:0] ut [5] = '{12'h667, 12'h767, 12'hF67, 12'h1D7, 12'h16F};

  store_exec DUT (.MCLK(mclk), .RST_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
    .INSTR_VALID(ivalid), .INSTR_READY(irdy), .INSTR(instr), .COND_PASS(cond), .CARRY_FLAG(carry),
    .RF_ADDR_A(ra), .RF_ADDR_B(rb), .RF_ADDR_C(rc), .RF_DATA_A(rf[ra]), .RF_DATA_B(rf[rb]),
    .RF_DATA_C(rf[rc]), .WB_EN(wb_en), .WB_REG(wb_reg), .WB_DATA(wb_data), .MEM_OUT(mem),
    .MEM_ACK(ack), .MEM_PROT_FAULT(pf), .MEM_BUS_FAULT(bf), .DONE(done), .RESULT(res));
  mem_port_model mem_i (.clk(mclk), .rst_n(rst_n), .req(mem), .wait_n(wait_n),
    .fault_sel(fault_sel), .ack(ack), .prot_fault(pf), .bus_fault(bf));

  always #12.5 mclk = ~mclk;
  // log writes and writebacks, and cut a hang short
  always @(posedge mclk) begin
    cyc++;
    if (mem.req === 1'b1 && ack === 1'b1)
      log_q.push_back(mem);
    if (wb_en === 1'b1) begin
      wb_cnt++;
      wbr = wb_reg;
      wbd = wb_data;
    end
    if (cyc == 3000) begin
      errors++;
      end_sim();
    end
  end

  // ======
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  // one apb transfer, idle edge after so psel is never set twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  // issue one word, wait for done, compare masked result and write count
  task automatic run(input logic [31:0] w, input logic c, input logic [5:0] x, m, input int n);
    int t;
    log_q.delete();
    wb_cnt = 0;
    instr <= w;
    cond <= c;
    ivalid <= 1'b1;
    do @(posedge mclk); while (irdy !== 1'b1);
    ivalid <= 1'b0;
    for (t = 0; t < 40 && done !== 1'b1; t++) @(posedge mclk);
    @(posedge mclk);
    chk(32'(t < 40), 32'h1);
    chk({26'h0, res & m}, {26'h0, x});
    chk(32'(log_q.size()), 32'(n));
  endtask : run
  task automatic mchk(input int i, input logic [31:0] a, d, input logic [1:0] fl);
    chk(log_q[i].addr, a);
    chk(fl[0] ? log_q[i].wdata : {24'h0, log_q[i].wdata[7:0]}, d);
    chk({30'h0, log_q[i].unpriv, log_q[i].word}, {30'h0, fl});
  endtask : mchk
  function automatic logic [31:0] ub(input logic [3:0] n, t, input logic [7:0] i);
    return {12'hF80, n, t, 4'hE, i};
  endfunction : ub
  function automatic logic [31:0] dw(input logic [10:0] c, input logic [11:0] r);
    return {7'h74, c[10:9], 1'b1, c[8], 1'b0, r, c[7:0]};
  endfunction : dw

  // ======
  initial begin
    {mclk, rst_n, psel, penable, pwrite, ivalid, paddr, pwdata, instr, fault_sel} = '0;
    {ce, cond, carry} = 3'b111;
    wait_n = 4'h2;
    for (int i = 0; i < 16; i++)
      rf[i] = 32'h1234_5000 + 32'(i) * 32'h0001_0111;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    apb(1'b0, OFS_CTRL, 32'h0, q, e);
    chk(q, 32'h0000_0001);
    apb(1'b0, OFS_IRQ_MASK, 32'h0, q, e);
    chk(q, 32'h0000_0000);
    apb(1'b1, 8'h20, 32'hFFFF_FFFF, q, e);
    chk({31'h0, e}, 32'h0000_0001);
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk({q[30:0], e}, 32'h0000_0001);
    $display("registers test done");
    // slow memory, shifted register offset
    run({12'hF80, 4'h1, 4'h3, 8'h02, 4'h2}, 1'b1, 6'h01, 6'h3F, 1);
    mchk(0, rf[1] + (rf[2] << 2), {24'h0, rf[3][7:0]}, 2'b00);
    for (int i = 0; i < 2; i++) begin
      run(ub(4'h1, 4'h4, i ? 8'hFF : 8'h00), 1'b1, 6'h01, 6'h3F, 1);
      mchk(0, rf[1] + (i ? 32'h0000_00FF : 32'h0), {24'h0, rf[4][7:0]}, 2'b10);
      chk(wb_cnt, 0);
    end
    wait_n <= 4'h0;
    run(ub(4'hF, 4'h4, 8'h10), 1'b1, 6'h02, 6'h3E, 0);
    run(ub(4'h1, 4'hD, 8'h10), 1'b1, 6'h04, 6'h3E, 0);
    run(ub(4'h1, 4'hF, 8'h10), 1'b1, 6'h04, 6'h3E, 0);
    $display("byte store tests done");
    // offset, pre-indexed and post-indexed, both directions
    for (int i = 0; i < 4; i++) begin
      off = {22'h0, tab[i][7:0], 2'b00};
      oa = tab[i][9] ? rf[1] + off : rf[1] - off;
      ad = tab[i][10] ? oa : rf[1];
      run(dw(tab[i], 12'h167), 1'b1, 6'h01, 6'h3F, 2);
      mchk(0, ad, rf[6], 2'b01);
      mchk(1, ad + 32'h4, rf[7], 2'b01);
      chk(wb_cnt, {31'h0, tab[i][8]});
      if (tab[i][8])
        chk({wbr, wbd[27:0]} ^ {4'h1, oa[27:0]}, 32'h0);
    end
    run(dw(11'h004, 12'h167), 1'b1, 6'h08, 6'h3E, 0);
    run(dw(11'h204, 12'h167), 1'b1, 6'h08, 6'h3E, 0);
    for (int i = 0; i < 5; i++)
      run(dw(11'h704, ut[i]), 1'b1, 6'h04, 6'h3E, 0);
    run(dw(11'h704, 12'h167), 1'b0, 6'h01, 6'h3F, 0);
    run({12'hF80, 4'h1, 4'h3, 8'h02, 4'h2}, 1'b0, 6'h01, 6'h3F, 0);
    chk(wb_cnt, 0);
    $display("dual store tests done");
    // protection fault raises the unmasked interrupt, then w1c clears it
    apb(1'b1, OFS_IRQ_MASK, 32'h1 << EV_PROT, q, e);
    fault_sel <= 2'b01;
    run(ub(4'h1, 4'h4, 8'h02), 1'b1, 6'h10, 6'h3E, 1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, OFS_IRQ_STAT, 32'h0, q, e);
    chk(q & (32'h1 << EV_PROT), 32'h1 << EV_PROT);
    apb(1'b1, OFS_IRQ_STAT, 32'h1 << EV_PROT, q, e);
    chk({31'h0, irq}, 32'h0);
    fault_sel <= 2'b00;
    log_q.delete();
    // bus fault on the second word: no writeback
    fork
      run(dw(11'h704, 12'h167), 1'b1, 6'h20, 6'h3E, 2);
      begin
        wait (log_q.size() == 1);
        fault_sel <= 2'b10;
      end
    join
    chk(wb_cnt, 0);
    apb(1'b0, OFS_FAULT_ADDR, 32'h0, q, e);
    chk(q, rf[1] + 32'h0000_0014);
    apb(1'b0, OFS_EXEC_COUNT, 32'h0, q, e);
    chk(q, 32'h0000_0007);
    $display("fault tests done");
    end_sim();
  end
endmodule : store_exec_tb
